// ---- rtl/dmc_arbiter.sv ----
// Purpose: Picks the next channel to serve among pending requests.
// Assumes: i_adv pulses in the cycle the granted channel is started.
// Notes:   Grant is combinational; the last served channel is registered.
`timescale 1ns/1ps
`default_nettype none
module dmc_arbiter #(
    parameter int N  = 4,
    parameter int IW = 2
) (
    // Clock and reset
    input  wire logic          i_sys_clk,
    input  wire logic          i_rst,
    // Requests
    input  wire logic [N-1:0]  i_req,
    input  wire logic          i_rr,
    input  wire logic          i_adv,
    // Grant
    output logic      [IW-1:0] o_gnt,
    output logic               o_valid
);

    typedef struct packed {
        logic [IW-1:0] last;
    } dmc_arb_type;

    dmc_arb_type q;
    dmc_arb_type d;

    always_comb begin
        int idx;
        idx = 0;
        d = q;
        o_gnt = '0;
        o_valid = 1'b0;
        for (int i = 0; i < N; i++) begin
            if (i_rr) begin
                idx = int'(q.last) + 1 + i;
                if (idx >= N) begin
                    idx = idx - N;
                end
            end else begin
                idx = i;
            end
            if (!o_valid && i_req[idx]) begin
                o_valid = 1'b1;
                o_gnt = IW'(idx);
            end
        end
        if (i_adv) begin
            d.last = o_gnt;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule // dmc_arbiter
`default_nettype wire

// ---- rtl/dmc_core.sv ----
// Purpose: DMA engine core control: registers, arbitration, bus mastering.
// Assumes: Peripheral read data is valid one cycle after the read strobe.
// Notes:   CPU demand for the DMA bus must be seen one cycle ahead.
`timescale 1ns/1ps
`default_nettype none
module dmc_core #(
    parameter int N = 4
) (
    // Clock and reset
    input  wire logic                       i_sys_clk,
    input  wire logic                       i_rst,
    // CPU register port
    input  wire logic [dmc_pkg::ADDR_W-1:0] i_cpu_addr,
    input  wire logic                       i_cpu_we,
    input  wire logic [15:0]                i_cpu_wdata,
    output logic      [15:0]                o_cpu_rdata,
    // CPU demand and channel triggers
    input  wire logic                       i_cpu_dbus_req,
    input  wire logic [N-1:0]               i_trig,
    // DMA peripheral bus master
    output logic      [15:0]                o_dbus_addr,
    output logic                            o_dbus_rd,
    output logic                            o_dbus_wr,
    output logic                            o_dbus_byte,
    output logic      [15:0]                o_dbus_wdata,
    input  wire logic [15:0]                i_dbus_rdata,
    // Status
    output logic                            o_busy
);

    localparam int IW = (N > 1) ? $clog2(N) : 1;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        dmc_pkg::dmc_state_type st;
        logic                   en;
        logic                   prs;
        logic [15:0]            upper;
        logic [15:0]            lower;
        logic [15:0]            hold;
        logic [N-1:0][15:0]     src;
        logic [N-1:0][15:0]     dst;
        logic [N-1:0][15:0]     cnt;
        logic [N-1:0]           chen;
        logic [N-1:0]           size;
        logic [N-1:0]           pend;
        logic [N-1:0][1:0]      sam;
        logic [N-1:0][1:0]      dam;
        logic [N-1:0][1:0]      trm;
        logic [N-1:0]           hif;
        logic [N-1:0]           lif;
        logic [N-1:0]           dif;
        logic [IW-1:0]          ch;
        logic [15:0]            rdata;
        logic [15:0]            addr;
        logic [15:0]            wdata;
        logic                   rd;
        logic                   wr;
        logic                   bsz;
        logic                   busy;
    } dmc_core_type;

    dmc_core_type    q;
    dmc_core_type    d;
    logic [IW-1:0]   gnt;
    logic            gnt_valid;
    logic            start;
    logic [N-1:0]    req;

    // ****************************************************************
    // Arbitration
    // ****************************************************************
    assign req = q.pend & q.chen & {N{q.en}};
    assign start = (q.st == dmc_pkg::ST_IDLE) && gnt_valid
                   && !i_cpu_dbus_req;

    dmc_arbiter #(
        .N  (N),
        .IW (IW)
    ) u_arb (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_req     (req),
        .i_rr      (q.prs),
        .i_adv     (start),
        .o_gnt     (gnt),
        .o_valid   (gnt_valid)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic [15:0] step;
        logic [15:0] ncnt;
        logic [7:0]  base;
        step = dmc_pkg::STEP_WORD;
        ncnt = dmc_pkg::ZERO16;
        base = dmc_pkg::CH_BASE;
        d = q;
        d.rd = 1'b0;
        d.wr = 1'b0;

        if (i_cpu_we) begin
            if (i_cpu_addr == dmc_pkg::CTL_IDX) begin
                d.en = i_cpu_wdata[dmc_pkg::EN_BIT];
                d.prs = i_cpu_wdata[dmc_pkg::PRS_BIT];
            end
            if (i_cpu_addr == dmc_pkg::UPPER_IDX) begin
                d.upper = i_cpu_wdata;
            end
            if (i_cpu_addr == dmc_pkg::LOWER_IDX) begin
                d.lower = i_cpu_wdata;
            end
            if (i_cpu_addr == dmc_pkg::BUF_IDX) begin
                d.hold = i_cpu_wdata;
            end
            for (int n = 0; n < N; n++) begin
                base = 8'(dmc_pkg::CH_BASE + n * dmc_pkg::CH_STRIDE);
                if (i_cpu_addr == 8'(base + dmc_pkg::CH_CTL_OFS)) begin
                    d.chen[n] = i_cpu_wdata[dmc_pkg::CHEN_BIT];
                    d.size[n] = i_cpu_wdata[dmc_pkg::SIZE_BIT];
                    d.trm[n] = i_cpu_wdata[dmc_pkg::TRM_LSB +: 2];
                    d.dam[n] = i_cpu_wdata[dmc_pkg::DAM_LSB +: 2];
                    d.sam[n] = i_cpu_wdata[dmc_pkg::SAM_LSB +: 2];
                    d.pend[n] = i_cpu_wdata[dmc_pkg::CHREQ_BIT];
                    if (!i_cpu_wdata[dmc_pkg::CHEN_BIT]) begin
                        d.cnt[n] = dmc_pkg::CNT_RESET;
                        d.pend[n] = 1'b0;
                    end
                end
                if (i_cpu_addr == 8'(base + dmc_pkg::CH_EVT_OFS)) begin
                    d.hif[n] = i_cpu_wdata[dmc_pkg::HIF_BIT];
                    d.lif[n] = i_cpu_wdata[dmc_pkg::LIF_BIT];
                    d.dif[n] = i_cpu_wdata[dmc_pkg::DIF_BIT];
                end
                if (i_cpu_addr == 8'(base + dmc_pkg::CH_SRC_OFS)) begin
                    d.src[n] = i_cpu_wdata;
                end
                if (i_cpu_addr == 8'(base + dmc_pkg::CH_DST_OFS)) begin
                    d.dst[n] = i_cpu_wdata;
                end
                if (i_cpu_addr == 8'(base + dmc_pkg::CH_CNT_OFS)) begin
                    d.cnt[n] = i_cpu_wdata;
                end
            end
        end

        unique case (q.st)
            dmc_pkg::ST_IDLE: begin
                if (start) begin
                    d.ch = gnt;
                    d.addr = q.src[gnt];
                    d.bsz = q.size[gnt];
                    d.rd = 1'b1;
                    d.st = dmc_pkg::ST_READ;
                end
            end
            dmc_pkg::ST_READ: begin
                d.st = dmc_pkg::ST_CAPT;
            end
            dmc_pkg::ST_CAPT: begin
                d.hold = q.bsz ? {8'h00, i_dbus_rdata[7:0]} : i_dbus_rdata;
                if (q.addr > q.upper) begin
                    d.hif[q.ch] = 1'b1;
                end
                if (q.addr < q.lower) begin
                    d.lif[q.ch] = 1'b1;
                end
                d.st = dmc_pkg::ST_WAITW;
            end
            dmc_pkg::ST_WAITW: begin
                if (!i_cpu_dbus_req) begin
                    d.addr = q.dst[q.ch];
                    d.wdata = q.hold;
                    d.wr = 1'b1;
                    d.st = dmc_pkg::ST_WRITE;
                end
            end
            dmc_pkg::ST_WRITE: begin
                step = q.bsz ? dmc_pkg::STEP_BYTE : dmc_pkg::STEP_WORD;
                if (q.sam[q.ch] == dmc_pkg::AM_INC) begin
                    d.src[q.ch] = q.src[q.ch] + step;
                end else if (q.sam[q.ch] == dmc_pkg::AM_DEC) begin
                    d.src[q.ch] = q.src[q.ch] - step;
                end
                if (q.dam[q.ch] == dmc_pkg::AM_INC) begin
                    d.dst[q.ch] = q.dst[q.ch] + step;
                end else if (q.dam[q.ch] == dmc_pkg::AM_DEC) begin
                    d.dst[q.ch] = q.dst[q.ch] - step;
                end
                if (q.addr > q.upper) begin
                    d.hif[q.ch] = 1'b1;
                end
                if (q.addr < q.lower) begin
                    d.lif[q.ch] = 1'b1;
                end
                ncnt = q.cnt[q.ch] - dmc_pkg::CNT_STEP;
                d.cnt[q.ch] = ncnt;
                if (ncnt == dmc_pkg::ZERO16) begin
                    d.dif[q.ch] = 1'b1;
                    d.chen[q.ch] = 1'b0;
                    d.pend[q.ch] = 1'b0;
                end else if (!q.trm[q.ch][dmc_pkg::TRM_CONT]) begin
                    d.pend[q.ch] = 1'b0;
                end
                d.st = dmc_pkg::ST_IDLE;
            end
            default: begin
                d.st = dmc_pkg::ST_IDLE;
            end
        endcase

        if (!q.en) begin
            d.st = dmc_pkg::ST_IDLE;
            d.rd = 1'b0;
            d.wr = 1'b0;
            d.pend = '0;
        end

        // Triggers arriving now win over any clear.
        for (int n = 0; n < N; n++) begin
            if (i_trig[n] && q.chen[n] && q.en) begin
                d.pend[n] = 1'b1;
            end
        end

        d.rdata = dmc_pkg::ZERO16;
        if (i_cpu_addr == dmc_pkg::CTL_IDX) begin
            d.rdata[dmc_pkg::EN_BIT] = q.en;
            d.rdata[dmc_pkg::PRS_BIT] = q.prs;
        end
        if (i_cpu_addr == dmc_pkg::UPPER_IDX) begin
            d.rdata = q.upper;
        end
        if (i_cpu_addr == dmc_pkg::LOWER_IDX) begin
            d.rdata = q.lower;
        end
        if (i_cpu_addr == dmc_pkg::BUF_IDX) begin
            d.rdata = q.hold;
        end
        for (int n = 0; n < N; n++) begin
            base = 8'(dmc_pkg::CH_BASE + n * dmc_pkg::CH_STRIDE);
            if (i_cpu_addr == 8'(base + dmc_pkg::CH_CTL_OFS)) begin
                d.rdata[dmc_pkg::CHEN_BIT] = q.chen[n];
                d.rdata[dmc_pkg::SIZE_BIT] = q.size[n];
                d.rdata[dmc_pkg::TRM_LSB +: 2] = q.trm[n];
                d.rdata[dmc_pkg::DAM_LSB +: 2] = q.dam[n];
                d.rdata[dmc_pkg::SAM_LSB +: 2] = q.sam[n];
                d.rdata[dmc_pkg::CHREQ_BIT] = q.pend[n];
            end
            if (i_cpu_addr == 8'(base + dmc_pkg::CH_EVT_OFS)) begin
                d.rdata[dmc_pkg::HIF_BIT] = q.hif[n];
                d.rdata[dmc_pkg::LIF_BIT] = q.lif[n];
                d.rdata[dmc_pkg::DIF_BIT] = q.dif[n];
            end
            if (i_cpu_addr == 8'(base + dmc_pkg::CH_SRC_OFS)) begin
                d.rdata = q.src[n];
            end
            if (i_cpu_addr == 8'(base + dmc_pkg::CH_DST_OFS)) begin
                d.rdata = q.dst[n];
            end
            if (i_cpu_addr == 8'(base + dmc_pkg::CH_CNT_OFS)) begin
                d.rdata = q.cnt[n];
            end
        end

        d.busy = (d.st != dmc_pkg::ST_IDLE);
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            q <= '0;
            q.st <= dmc_pkg::ST_IDLE;
            q.cnt <= {N{dmc_pkg::CNT_RESET}};
        end else begin
            q <= d;
        end
    end

    assign o_cpu_rdata  = q.rdata;
    assign o_dbus_addr  = q.addr;
    assign o_dbus_rd    = q.rd;
    assign o_dbus_wr    = q.wr;
    assign o_dbus_byte  = q.bsz;
    assign o_dbus_wdata = q.wdata;
    assign o_busy       = q.busy;

endmodule // dmc_core
`default_nettype wire

// ---- rtl/dmc_pkg.sv ----
// Purpose: Shared constants and types of the DMA engine core control.
// Assumes: Registers are 16-bit words at word indices on the CPU port.
package dmc_pkg;

    // ****************************************************************
    // Register map, word indices
    // ****************************************************************
    localparam int          ADDR_W     = 8;
    localparam logic [7:0]  CTL_IDX    = 8'h00;
    localparam logic [7:0]  UPPER_IDX  = 8'h01;
    localparam logic [7:0]  LOWER_IDX  = 8'h02;
    localparam logic [7:0]  BUF_IDX    = 8'h03;
    localparam logic [7:0]  CH_BASE    = 8'h04;
    localparam int          CH_STRIDE  = 5;
    localparam int          CH_CTL_OFS = 0;
    localparam int          CH_EVT_OFS = 1;
    localparam int          CH_SRC_OFS = 2;
    localparam int          CH_DST_OFS = 3;
    localparam int          CH_CNT_OFS = 4;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int EN_BIT    = 15;
    localparam int PRS_BIT   = 0;
    localparam int CHEN_BIT  = 0;
    localparam int SIZE_BIT  = 1;
    localparam int TRM_LSB   = 2;
    localparam int DAM_LSB   = 4;
    localparam int SAM_LSB   = 6;
    localparam int CHREQ_BIT = 8;
    localparam int HIF_BIT   = 7;
    localparam int LIF_BIT   = 6;
    localparam int DIF_BIT   = 5;
    localparam int TRM_CONT  = 1;

    // ****************************************************************
    // Values
    // ****************************************************************
    localparam logic [1:0]  AM_INC    = 2'h1;
    localparam logic [1:0]  AM_DEC    = 2'h2;
    localparam logic [15:0] ZERO16    = 16'h0000;
    localparam logic [15:0] CNT_RESET = 16'h0001;
    localparam logic [15:0] CNT_STEP  = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [15:0] STEP_BYTE = 16'h0001;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_READ  = 3'h1,
        ST_CAPT  = 3'h3,
        ST_WAITW = 3'h2,
        ST_WRITE = 3'h6
    } dmc_state_type;

endpackage

// ---- sim/dma_module_core_control_test.sv ----
// Purpose: Self-checking bench of the DMA engine core control.
// Assumes: Memory model word at index i holds A000h plus i.
// Notes:   Register port driven 1 ns after each rising edge.
`timescale 1ns/1ps
`default_nettype none
module dma_module_core_control_test;
    // ****************
    // Signals
    // ****************
    localparam int N = 4;
    logic         i_sys_clk;
    logic         i_rst;
    logic [7:0]   i_cpu_addr;
    logic         i_cpu_we;
    logic [15:0]  i_cpu_wdata;
    logic [15:0]  o_cpu_rdata;
    logic         i_cpu_dbus_req;
    logic [N-1:0] i_trig;
    logic [15:0]  o_dbus_addr;
    logic         o_dbus_rd;
    logic         o_dbus_wr;
    logic         o_dbus_byte;
    logic [15:0]  o_dbus_wdata;
    logic [15:0]  i_dbus_rdata;
    logic         o_busy;
    logic [15:0]  reads[$];
    logic [15:0]  fixed_ord [4] = '{16'h0100, 16'h0100, 16'h0120, 16'h0120};
    int           mismatches = 0;
    int           compares = 0;
    int           n;
    dmc_core #(.N(N)) DUT (.i_sys_clk, .i_rst, .i_cpu_addr, .i_cpu_we,
        .i_cpu_wdata, .o_cpu_rdata, .i_cpu_dbus_req, .i_trig, .o_dbus_addr,
        .o_dbus_rd, .o_dbus_wr, .o_dbus_byte, .o_dbus_wdata, .i_dbus_rdata,
        .o_busy);
    dmc_dbus_model PART (.i_sys_clk, .i_addr(o_dbus_addr), .i_rd(o_dbus_rd),
        .i_wr(o_dbus_wr), .i_byte(o_dbus_byte), .i_wdata(o_dbus_wdata),
        .o_rdata(i_dbus_rdata));
    initial begin
        i_sys_clk = 1'b0;
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) begin
        if (o_dbus_rd === 1'b1) begin
            reads.push_back(o_dbus_addr);
        end
    end
    // ****************
    // Tasks
    // ****************
    function automatic logic [7:0] ci(input int ch, input int ofs);
        return dmc_pkg::CH_BASE + 8'(dmc_pkg::CH_STRIDE * ch + ofs);
    endfunction
    task automatic give_verdict();
        if (mismatches == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_sys_clk);
        #1;
        i_cpu_addr = a;
        i_cpu_wdata = d;
        i_cpu_we = 1'b1;
        @(posedge i_sys_clk);
        #1;
        i_cpu_we = 1'b0;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge i_sys_clk);
        #1;
        i_cpu_addr = a;
        @(posedge i_sys_clk);
        #1;
        chk(o_cpu_rdata, exp);
    endtask
    task automatic setup_ch(input int ch, input logic [15:0] src, dst, cnt,
                            input logic [15:0] ctl);
        reg_wr(ci(ch, 4), cnt);
        reg_wr(ci(ch, 2), src);
        reg_wr(ci(ch, 3), dst);
        reg_wr(ci(ch, 0), ctl);
    endtask
    task automatic wait_reads(input int k);
        int w;
        w = 0;
        while (reads.size() < k && w < 300) begin
            @(posedge i_sys_clk);
            w++;
        end
        if (reads.size() < k) begin
            mismatches++;
            $display("MISMATCH %0t transfer timed out", $time);
            give_verdict();
        end
        repeat (6) @(posedge i_sys_clk);
    endtask
    task automatic cpu_req(input logic v);
        @(posedge i_sys_clk);
        #1;
        i_cpu_dbus_req = v;
    endtask
    // ****************
    // Sequence
    // ****************
    initial begin
        i_rst = 1'b1;
        i_cpu_addr = 8'h00;
        i_cpu_we = 1'b0;
        i_cpu_wdata = 16'h0000;
        i_cpu_dbus_req = 1'b0;
        i_trig = '0;
        repeat (4) @(posedge i_sys_clk);
        #1;
        i_rst = 1'b0;
        chk_rd(dmc_pkg::CTL_IDX, 16'h0000);
        chk_rd(ci(0, 4), 16'h0001);
        reg_wr(ci(N, 0), 16'hFFFF);
        chk_rd(ci(N, 0), 16'h0000);
        reg_wr(dmc_pkg::CTL_IDX, 16'hFFFF);
        chk_rd(dmc_pkg::CTL_IDX, 16'h8001);
        reg_wr(dmc_pkg::CTL_IDX, 16'h8000);
        reg_wr(dmc_pkg::UPPER_IDX, 16'h01FF);
        reg_wr(dmc_pkg::LOWER_IDX, 16'h0080);
        chk_rd(dmc_pkg::UPPER_IDX, 16'h01FF);
        chk_rd(dmc_pkg::LOWER_IDX, 16'h0080);
        setup_ch(0, 16'h0100, 16'h0200, 16'h0002, 16'h0059);
        @(posedge i_sys_clk);
        #1;
        i_trig = 4'h1;
        @(posedge i_sys_clk);
        #1;
        i_trig = 4'h0;
        wait_reads(2);
        chk(reads[1], 16'h0102);
        chk(PART.mem[10'h100], 16'hA080);
        chk(PART.mem[10'h101], 16'hA081);
        chk_rd(ci(0, 2), 16'h0104);
        chk_rd(ci(0, 3), 16'h0204);
        chk_rd(ci(0, 4), 16'h0000);
        chk_rd(ci(0, 1), 16'h00A0);
        chk_rd(ci(0, 0), 16'h0058);
        chk_rd(dmc_pkg::BUF_IDX, 16'hA081);
        reg_wr(ci(0, 1), 16'h0000);
        chk_rd(ci(0, 1), 16'h0000);
        // Byte transfer held off by CPU.
        cpu_req(1'b1);
        reads.delete();
        setup_ch(1, 16'h0110, 16'h0210, 16'h0001, 16'h0103);
        repeat (10) @(posedge i_sys_clk);
        chk(16'(reads.size()), 16'h0000);
        cpu_req(1'b0);
        wait_reads(1);
        chk(PART.mem[10'h108], 16'hA188);
        chk_rd(ci(1, 3), 16'h0210);
        for (int m = 0; m < 2; m++) begin
            cpu_req(1'b1);
            reads.delete();
            reg_wr(dmc_pkg::CTL_IDX, m ? 16'h8001 : 16'h8000);
            setup_ch(0, 16'h0100, 16'h0180, 16'h0002, 16'h0109);
            setup_ch(1, 16'h0120, 16'h0180, 16'h0002, 16'h0109);
            cpu_req(1'b0);
            wait_reads(4);
            for (int i = 0; i < 4; i++) begin
                if (m == 0) begin
                    chk(reads[i], fixed_ord[i]);
                end else if (i < 3) begin
                    chk({15'h0, reads[i] == reads[i + 1]}, 16'h0000);
                end
            end
        end
        reads.delete();
        setup_ch(0, 16'h0100, 16'h0180, 16'h0008, 16'h0109);
        wait_reads(2);
        reg_wr(dmc_pkg::CTL_IDX, 16'h0000);
        @(posedge i_sys_clk);
        #1;
        chk({15'h0, o_busy}, 16'h0000);
        n = reads.size();
        repeat (10) @(posedge i_sys_clk);
        chk(16'(reads.size()), 16'(n));
        reg_wr(ci(0, 0), 16'h0000);
        chk_rd(ci(0, 4), 16'h0001);
        reg_wr(dmc_pkg::CTL_IDX, 16'h8000);
        repeat (10) @(posedge i_sys_clk);
        chk(16'(reads.size()), 16'(n));
        // Write held off; one-shot with decrement.
        reads.delete();
        setup_ch(2, 16'h0072, 16'h0184, 16'h0002, 16'h01A1);
        cpu_req(1'b1);
        repeat (10) @(posedge i_sys_clk);
        #1;
        chk(PART.mem[10'hC2], 16'hA0C2);
        chk({15'h0, o_busy}, 16'h0001);
        cpu_req(1'b0);
        wait_reads(1);
        chk(PART.mem[10'hC2], 16'hA039);
        chk(16'(reads.size()), 16'h0001);
        chk_rd(ci(2, 2), 16'h0070);
        chk_rd(ci(2, 3), 16'h0182);
        chk_rd(ci(2, 4), 16'h0001);
        chk_rd(ci(2, 1), 16'h0040);
        chk_rd(ci(2, 0), 16'h00A1);
        give_verdict();
    end
endmodule // dma_module_core_control_test
`default_nettype wire

// ---- sim/dmc_core_sva.sv ----
// Purpose: Port checker of the DMA engine core control.
// Assumes: One clock and a synchronous active-high reset.
// Notes:   Bound to every dmc_core instance.
`timescale 1ns/1ps
`default_nettype none
module dmc_core_sva #(
    parameter int N = 4
) (
    // Clock and reset
    input wire logic                       i_sys_clk,
    input wire logic                       i_rst,
    // CPU side
    input wire logic [dmc_pkg::ADDR_W-1:0] i_cpu_addr,
    input wire logic                       i_cpu_we,
    input wire logic [15:0]                i_cpu_wdata,
    input wire logic [15:0]                o_cpu_rdata,
    input wire logic                       i_cpu_dbus_req,
    // Peripheral bus
    input wire logic                       o_dbus_rd,
    input wire logic                       o_dbus_wr,
    input wire logic                       o_busy
);
    // ****************
    // Properties
    // ****************
    localparam logic [7:0] LIM = 8'(int'(dmc_pkg::CH_BASE) + 5 * N);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    sequence s_up_wr;
        i_cpu_we && i_cpu_addr == dmc_pkg::UPPER_IDX
            ##1 !i_cpu_we && i_cpu_addr == dmc_pkg::UPPER_IDX;
    endsequence
    property p_cpu_rd; i_cpu_dbus_req |=> !o_dbus_rd; endproperty
    a_cpu_rd: assert property (p_cpu_rd)
        else $error("read strobe while CPU holds the bus");
    property p_cpu_wr; i_cpu_dbus_req |=> !o_dbus_wr; endproperty
    a_cpu_wr: assert property (p_cpu_wr)
        else $error("write strobe while CPU holds the bus");
    property p_rd_pulse; o_dbus_rd |=> !o_dbus_rd; endproperty
    a_rd_pulse: assert property (p_rd_pulse)
        else $error("read strobe longer than one cycle");
    property p_rd_start; o_dbus_rd |-> o_busy && !$past(o_busy); endproperty
    a_rd_start: assert property (p_rd_start)
        else $error("read strobe not at start of transfer");
    property p_gap; o_dbus_rd |=> !o_dbus_wr [*2]; endproperty
    a_gap: assert property (p_gap)
        else $error("write too soon after read");
    property p_wr_end; o_dbus_wr |=> !o_busy && !o_dbus_rd; endproperty
    a_wr_end: assert property (p_wr_end)
        else $error("transfer does not end after write");
    property p_ctl_zero;
        $past(i_cpu_addr) == dmc_pkg::CTL_IDX |-> o_cpu_rdata[14:1] == 14'h0;
    endproperty
    a_ctl_zero: assert property (p_ctl_zero)
        else $error("control reserved bits read nonzero");
    property p_unmap; $past(i_cpu_addr) >= LIM |-> o_cpu_rdata == 16'h0;
    endproperty
    a_unmap: assert property (p_unmap)
        else $error("unmapped index read nonzero");
    property p_up_rb; s_up_wr |=> o_cpu_rdata == $past(i_cpu_wdata, 2);
    endproperty
    a_up_rb: assert property (p_up_rb)
        else $error("upper limit readback wrong");
endmodule // dmc_core_sva
bind dmc_core dmc_core_sva #(.N(N)) u_sva (.i_sys_clk, .i_rst, .i_cpu_addr,
    .i_cpu_we, .i_cpu_wdata, .o_cpu_rdata, .i_cpu_dbus_req, .o_dbus_rd,
    .o_dbus_wr, .o_busy);
`default_nettype wire

// ---- sim/dmc_dbus_model.sv ----
// Purpose: Peripheral memory on the DMA bus.
// Assumes: Read data is due the cycle after the read strobe.
// Notes:   Outside that cycle the data lines toggle every cycle.
`timescale 1ns/1ps
`default_nettype none
module dmc_dbus_model (
    // Bus from the engine
    input  wire logic        i_sys_clk,
    input  wire logic [15:0] i_addr,
    input  wire logic        i_rd,
    input  wire logic        i_wr,
    input  wire logic        i_byte,
    input  wire logic [15:0] i_wdata,
    // Read data
    output logic      [15:0] o_rdata
);
    // ****************
    // Memory
    // ****************
    logic [15:0] mem [0:1023];
    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem[i] = 16'hA000 + 16'(i);
        end
        o_rdata = 16'h0000;
    end
    always @(posedge i_sys_clk) begin
        if (i_rd) begin
            o_rdata <= mem[i_addr[10:1]];
        end else begin
            o_rdata <= ~o_rdata;
        end
        if (i_wr && i_byte) begin
            mem[i_addr[10:1]][7:0] <= i_wdata[7:0];
        end else if (i_wr) begin
            mem[i_addr[10:1]] <= i_wdata;
        end
    end
endmodule // dmc_dbus_model
`default_nettype wire
